/* bootstrap_signaling_codec_bench.sv */
`timescale 1ns/1ps
module bootstrap_signaling_codec_bench;
    localparam int MS = 2;
    localparam int LIM = 12000;
    logic clk_i;
    logic rst_n_i = 1'b0;
    logic req_i = 1'b0;
    logic [2:0] minor_i = 3'h0;
    logic wake_first_i = 1'b0;
    logic [4:0] interval_code_i = 5'h00;
    logic [1:0] bandwidth_i = 2'h0;
    logic wake_second_i = 1'b0;
    logic [6:0] rate_mult_i = 7'h00;
    logic [7:0] preamble_i = 8'h00;
    logic ready_o, err_o, late_o, valid_o, reserved_o, valid2_o, reserved2_o;
    logic [2:0] minor_o;
    logic [1:0] wake_o;
    logic [4:0] interval_code_o;
    logic [12:0] interval_ms_o;
    logic [1:0] bandwidth_o;
    logic [6:0] rate_mult_o;
    logic [6:0] mult2_o;
    logic [15:0] rate_khz_o;
    logic [7:0] preamble_o;
    logic [15:0] seeds [8] = '{16'h019d, 16'h00ed, 16'h01e8, 16'h00e8,
        16'h00fb, 16'h0021, 16'h0054, 16'h00ec};
    logic [4:0] corner [8] = '{5'h00, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h17,
        5'h18, 5'h1e};
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int k;

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    bsc_link_if link ();
    bsc_link_if link2 ();
    bsc_tx #(.MS_CYCLES(MS)) u_bsc_tx (.clk_i, .rst_n_i, .req_i, .minor_i,
        .wake_first_i, .interval_code_i, .bandwidth_i, .wake_second_i,
        .rate_mult_i, .preamble_i, .ready_o, .err_o, .late_o, .link);
    bsc_rx u_bsc_rx (.clk_i, .rst_n_i, .link, .valid_o, .reserved_o,
        .minor_o, .wake_o, .interval_code_o, .interval_ms_o, .bandwidth_o,
        .rate_mult_o, .rate_khz_o, .preamble_o);
    // Second receiver faces a bench driver that may send reserved content
    bsc_rx u_bsc_rx_2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link2),
        .valid_o(valid2_o), .reserved_o(reserved2_o), .minor_o(),
        .wake_o(), .interval_code_o(), .interval_ms_o(), .bandwidth_o(),
        .rate_mult_o(mult2_o), .rate_khz_o(), .preamble_o());
    bsc_link_props u_bsc_link_props (.clk_i, .rst_n_i,
        .valid(link.valid), .idx(link.idx), .root(link.root),
        .seed(link.seed), .sig(link.sig), .rel_shift(link.rel_shift),
        .abs_shift(link.abs_shift));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [12:0] ms_of(input logic [4:0] x);
        if (x < 5'h08)
            return 13'h0032 * x + 13'h0032;
        if (x < 5'h10)
            return 13'h0064 * (x - 5'h08) + 13'h01f4;
        if (x < 5'h18)
            return 13'h00c8 * (x - 5'h10) + 13'h0514;
        return 13'h0190 * (x - 5'h18) + 13'h0b54;
    endfunction : ms_of

    function automatic logic [10:0] gray_of(input logic [7:0] s);
        logic [10:0] r;
        logic acc;
        r = 11'h004;
        acc = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            acc = acc ^ s[7-i];
            r[10-i] = acc;
        end
        return r;
    endfunction : gray_of

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick_until(ref logic flag, input int lim);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < lim)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (flag !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
    endtask : tick_until

    task automatic send(input logic [2:0] mi, input logic [1:0] wk,
        input logic [4:0] cd, input logic [1:0] b, input logic [6:0] m,
        input logic [7:0] p, input logic bad);
        int t0;
        logic seen;
        seen = 1'b0;
        tick_until(ready_o, LIM);
        @(posedge clk_i);
        req_i <= 1'b1;
        minor_i <= mi;
        wake_first_i <= wk[0];
        wake_second_i <= wk[1];
        interval_code_i <= cd;
        bandwidth_i <= b;
        rate_mult_i <= m;
        preamble_i <= p;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1;
        t0 = cyc;
        check(err_o, bad);
        if (bad)
        begin
            repeat (6)
            begin
                seen = seen | link.valid;
                @(posedge clk_i);
                #1;
            end
            check(seen, 1'b0);
            return;
        end
        @(posedge clk_i);
        #1 check(link.seed, seeds[mi]);
        tick_until(valid_o, 10);
        check(reserved_o, 1'b0);
        check(minor_o, mi);
        check(wake_o, wk);
        check(interval_code_o, cd);
        check(interval_ms_o, ms_of(cd));
        check(bandwidth_o, b);
        check(rate_mult_o, m);
        check(rate_khz_o, (16'(m) + 16'h0010) * 16'h0180);
        check(preamble_o, p);
        check(late_o, 1'b0);
        tick_until(ready_o, LIM);
        t0 = cyc - t0;
        check(t0 >= ms_of(cd) * MS && t0 <= ms_of(cd) * MS + MS + 3, 1);
    endtask : send

    task automatic drive2(input logic [7:0] b1, input logic [7:0] b2,
        input logic res);
        logic [7:0] s [4];
        logic [10:0] a;
        s = '{8'h00, b1, b2, 8'h5a};
        a = 11'h000;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            a = (i == 0) ? 11'h000 : 11'(a + gray_of(s[i]));
            link2.valid <= 1'b1;
            link2.idx <= 2'(i);
            link2.sig <= s[i];
            link2.rel_shift <= (i == 0) ? 11'h000 : gray_of(s[i]);
            link2.abs_shift <= a;
        end
        @(posedge clk_i);
        link2.valid <= 1'b0;
        link2.sig <= ~s[3];
        link2.abs_shift <= ~a;
        #1;
        tick_until(valid2_o, 8);
        check(reserved2_o, res);
        check(mult2_o, 7'h21);
    endtask : drive2

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        link2.valid = 1'b0;
        link2.root = 11'h089;
        link2.seed = 16'h019d;
        k = $urandom(32'hf71d);
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 8; k++)
            send(3'(k), 2'($urandom), corner[k], 2'(k % 3),
                (k == 7) ? 7'h50 : 7'($urandom % 81), 8'($urandom), 1'b0);
        $display("test corners done");
        for (k = 0; k < 12; k++)
            send(3'($urandom), 2'($urandom), 5'($urandom % 16),
                2'($urandom % 3), 7'($urandom % 81), 8'($urandom), 1'b0);
        $display("test random done");
        send(3'h0, 2'h0, 5'h1f, 2'h0, 7'h00, 8'h00, 1'b1);
        send(3'h1, 2'h1, 5'h02, 2'h3, 7'h00, 8'h00, 1'b1);
        send(3'h2, 2'h2, 5'h02, 2'h0, 7'h51, 8'h00, 1'b1);
        send(3'h3, 2'h3, 5'h02, 2'h0, 7'h7f, 8'h00, 1'b1);
        $display("test refusals done");
        send(3'h0, 2'h0, 5'h00, 2'h0, 7'h00, 8'h00, 1'b0);
        check(late_o, 1'b0);
        repeat (104) @(posedge clk_i);
        #1;
        check(late_o, 1'b1);
        send(3'h4, 2'h3, 5'h01, 2'h2, 7'h10, 8'hff, 1'b0);
        $display("test late done");
        drive2(8'h09, 8'h21, 1'b0);
        drive2(8'h09, 8'hd1, 1'b1);
        drive2(8'h8b, 8'h05, 1'b1);
        drive2(8'h7c, 8'h05, 1'b1);
        drive2(8'h0c, 8'h7f, 1'b1);
        $display("test reserved receive done");
        final_report();
    end
endmodule : bootstrap_signaling_codec_bench

/* bsc_link_if.sv */
`timescale 1ns/1ps
interface bsc_link_if;
    logic valid;
    logic [1:0] idx;
    logic [10:0] root;
    logic [15:0] seed;
    logic [7:0] sig;
    logic [10:0] rel_shift;
    logic [10:0] abs_shift;

    modport tx_mp (
        output valid,
        output idx,
        output root,
        output seed,
        output sig,
        output rel_shift,
        output abs_shift
    );

    modport rx_mp (
        input valid,
        input idx,
        input root,
        input seed,
        input sig,
        input rel_shift,
        input abs_shift
    );
endinterface : bsc_link_if

/* bsc_link_props.sv */
`timescale 1ns/1ps
module bsc_link_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid,
    input wire logic [1:0] idx,
    input wire logic [10:0] root,
    input wire logic [15:0] seed,
    input wire logic [7:0] sig,
    input wire logic [10:0] rel_shift,
    input wire logic [10:0] abs_shift
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------
    // Expected shift for a signaling byte
    // ----------------------------------------
    function automatic logic [10:0] gray_of(input logic [7:0] s);
        logic [10:0] r;
        logic acc;
        r = 11'h004;
        acc = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            acc = acc ^ s[7-k];
            r[10-k] = acc;
        end
        return r;
    endfunction : gray_of

    property p_root;
        valid |-> root == 11'h089;
    endproperty
    a_root: assert property (p_root)
        else $error("root value wrong");
    property p_four;
        valid && idx == 2'h0 |=> valid && idx == 2'h1 ##1 valid && idx == 2'h2
            ##1 valid && idx == 2'h3 ##1 !valid;
    endproperty
    a_four: assert property (p_four)
        else $error("symbol count or order wrong");
    property p_seed;
        valid |-> seed inside {16'h019d, 16'h00ed, 16'h01e8, 16'h00e8,
            16'h00fb, 16'h0021, 16'h0054, 16'h00ec};
    endproperty
    a_seed: assert property (p_seed)
        else $error("seed not a known version");
    property p_seed_hold;
        valid && idx != 2'h0 |-> $stable(seed);
    endproperty
    a_seed_hold: assert property (p_seed_hold)
        else $error("seed changed inside bootstrap");
    property p_sync;
        valid && idx == 2'h0 |-> sig == 8'h00 && rel_shift == 11'h000
            && abs_shift == 11'h000;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync symbol not at zero shift");
    property p_abs;
        valid && idx != 2'h0 |->
            abs_shift == 11'($past(abs_shift) + rel_shift);
    endproperty
    a_abs: assert property (p_abs)
        else $error("absolute shift not accumulated");
    property p_gray;
        valid && idx != 2'h0 |-> rel_shift == gray_of(sig);
    endproperty
    a_gray: assert property (p_gray)
        else $error("relative shift mapping wrong");
    property p_no_code31;
        valid && idx == 2'h1 |-> sig[6:2] != 5'h1f;
    endproperty
    a_no_code31: assert property (p_no_code31)
        else $error("interval code 31 sent");
    property p_no_wide;
        valid && idx == 2'h1 |-> sig[1:0] != 2'h3;
    endproperty
    a_no_wide: assert property (p_no_wide)
        else $error("wide bandwidth code sent");
    property p_mult;
        valid && idx == 2'h2 |-> sig[6:0] <= 7'h50;
    endproperty
    a_mult: assert property (p_mult)
        else $error("reserved multiplier sent");
endmodule : bsc_link_props

/* bsc_params.svh */
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ----------------------------------------------------------------
// Version identification
// ----------------------------------------------------------------
`define BSC_ROOT_V0 11'h089
`define BSC_SEED_V0 16'h019D
`define BSC_SEED_V1 16'h00ED
`define BSC_SEED_V2 16'h01E8
`define BSC_SEED_V3 16'h00E8
`define BSC_SEED_V4 16'h00FB
`define BSC_SEED_V5 16'h0021
`define BSC_SEED_V6 16'h0054
`define BSC_SEED_V7 16'h00EC
`define BSC_FIRST_SYM 2'h0
`define BSC_LAST_SYM 2'h3

// ----------------------------------------------------------------
// Field limits
// ----------------------------------------------------------------
`define BSC_CODE_NONE 5'h1F
`define BSC_BW_WIDE 2'h3
`define BSC_MULT_MAX 7'h50
`define BSC_RATE_OFS 16'h0010
`define BSC_RATE_STEP_KHZ 16'h0180

// ----------------------------------------------------------------
// Interval scale in ms: base and step per segment
// ----------------------------------------------------------------
`define BSC_T_BASE0 13'h0032
`define BSC_T_BASE1 13'h01F4
`define BSC_T_BASE2 13'h0514
`define BSC_T_BASE3 13'h0B54
`define BSC_T_STEP0 13'h0032
`define BSC_T_STEP1 13'h0064
`define BSC_T_STEP2 13'h00C8
`define BSC_T_STEP3 13'h0190
`define BSC_T_SAT 13'h1FFF

// ----------------------------------------------------------------
// Shift mapping and timing
// ----------------------------------------------------------------
`define BSC_SHIFT_ONE_POS 2
`define BSC_CLK_PERIOD_NS 8
`define BSC_MS_NS 1000000
`define BSC_MS_CYCLES (`BSC_MS_NS / `BSC_CLK_PERIOD_NS)

`endif

/* bsc_pkg.sv */
package bsc_pkg;
`include "bsc_params.svh"

    typedef enum logic [0:0] {BSC_IDLE, BSC_SEND} bsc_tx_st_t;

    typedef struct packed {
        bsc_tx_st_t state;
        logic [1:0] sym;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [15:0] seed;
        logic [16:0] div;
        logic [12:0] elapsed;
        logic [12:0] lo;
        logic [12:0] hi;
        logic armed;
        logic ready;
        logic err;
        logic late;
        logic lk_valid;
        logic [1:0] lk_idx;
        logic [10:0] lk_root;
        logic [15:0] lk_seed;
        logic [7:0] lk_sig;
        logic [10:0] lk_rel;
        logic [10:0] lk_abs;
    } bsc_tx_state_t;

    typedef struct packed {
        logic [1:0] expect_idx;
        logic bad;
        logic [2:0] minor;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [10:0] abs;
        logic valid;
        logic reserved;
        logic [2:0] minor_o;
        logic [1:0] wake;
        logic [4:0] code;
        logic [12:0] ms;
        logic [1:0] bw;
        logic [6:0] mult;
        logic [15:0] khz;
        logic [7:0] pre;
    } bsc_rx_state_t;

    function automatic logic [15:0] bsc_seed(input logic [2:0] minor);
        logic [15:0] s;
        s = `BSC_SEED_V0;
        case (minor)
            3'h1: s = `BSC_SEED_V1;
            3'h2: s = `BSC_SEED_V2;
            3'h3: s = `BSC_SEED_V3;
            3'h4: s = `BSC_SEED_V4;
            3'h5: s = `BSC_SEED_V5;
            3'h6: s = `BSC_SEED_V6;
            3'h7: s = `BSC_SEED_V7;
            default: s = `BSC_SEED_V0;
        endcase
        return s;
    endfunction : bsc_seed

    // Segment offset is always the low three code bits
    function automatic logic [12:0] bsc_interval_ms(input logic [4:0] x);
        logic [12:0] off;
        logic [12:0] t;
        off = {10'h000, x[2:0]};
        case (x[4:3])
            2'h0: t = `BSC_T_BASE0 + `BSC_T_STEP0 * off;
            2'h1: t = `BSC_T_BASE1 + `BSC_T_STEP1 * off;
            2'h2: t = `BSC_T_BASE2 + `BSC_T_STEP2 * off;
            default: t = `BSC_T_BASE3 + `BSC_T_STEP3 * off;
        endcase
        return t;
    endfunction : bsc_interval_ms

endpackage : bsc_pkg

/* bsc_rx.sv */
`timescale 1ns/1ps
module bsc_rx
    import bsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    bsc_link_if.rx_mp link,
    output logic valid_o,
    output logic reserved_o,
    output logic [2:0] minor_o,
    output logic [1:0] wake_o,
    output logic [4:0] interval_code_o,
    output logic [12:0] interval_ms_o,
    output logic [1:0] bandwidth_o,
    output logic [6:0] rate_mult_o,
    output logic [15:0] rate_khz_o,
    output logic [7:0] preamble_o
);

    // ----------------------------------------------------------------
    // Seed lookup and shift check
    // ----------------------------------------------------------------
    bsc_rx_state_t r;
    bsc_rx_state_t n;
    logic [10:0] exp_rel;
    logic seed_ok;
    logic [2:0] seed_minor;

    bsc_shift_map u_map (
        .sig_i(link.sig),
        .shift_o(exp_rel)
    );

    // R3: seed back to minor version
    always_comb
    begin
        seed_ok = 1'b0;
        seed_minor = 3'h0;
        for (int k = 0; k < 8; k++)
        begin
            if (link.seed == bsc_seed(3'(k)))
            begin
                seed_ok = 1'b1;
                seed_minor = 3'(k);
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // expect_idx of zero means waiting for a sync symbol.
    always_comb
    begin
        n = r;
        n.valid = 1'b0;
        if (link.valid)
        begin
            if (link.idx == `BSC_FIRST_SYM)
            begin
                n.expect_idx = 2'h1;
                n.minor = seed_minor;
                n.abs = '0;
                // R1: root must be 137
                // R21: sync shift must be zero
                n.bad = (link.root != `BSC_ROOT_V0) || !seed_ok ||
                        (link.abs_shift != 11'h000);
            end
            else if (link.idx == r.expect_idx)
            begin
                n.expect_idx = r.expect_idx + 2'h1;
                n.abs = link.abs_shift;
                // R20: shift must match bits
                // R21: accumulated shift must match
                if ((link.rel_shift != exp_rel) ||
                    (link.abs_shift != r.abs + link.rel_shift) ||
                    (link.root != `BSC_ROOT_V0))
                begin
                    n.bad = 1'b1;
                end
                if (link.idx == 2'h1)
                begin
                    n.b1 = link.sig;
                end
                if (link.idx == 2'h2)
                begin
                    n.b2 = link.sig;
                end
                if (link.idx == `BSC_LAST_SYM)
                begin
                    // R22: one valid pulse
                    n.valid = 1'b1;
                    n.expect_idx = 2'h0;
                    // R15: reserved multiplier flagged
                    n.reserved = n.bad || (r.b2[6:0] > `BSC_MULT_MAX) ||
                                 (r.b1[1:0] == `BSC_BW_WIDE) ||
                                 (r.b1[6:2] == `BSC_CODE_NONE);
                    // R16: reserved bootstrap discarded
                    if (!n.reserved)
                    begin
                        n.minor_o = r.minor;
                        // R19: {second, first} wake
                        n.wake = {r.b2[7], r.b1[7]};
                        // R6: unpack symbol 1
                        n.code = r.b1[6:2];
                        // R8: interval in ms
                        n.ms = bsc_interval_ms(r.b1[6:2]);
                        // R10: bandwidth code out
                        n.bw = r.b1[1:0];
                        // R13: unpack symbol 2
                        n.mult = r.b2[6:0];
                        // R14: rate in kHz
                        n.khz = (`BSC_RATE_OFS + {9'h000, r.b2[6:0]}) *
                                `BSC_RATE_STEP_KHZ;
                        // R18: preamble passed unchecked
                        n.pre = link.sig;
                    end
                end
            end
            else
            begin
                n.expect_idx = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign valid_o = r.valid;
    assign reserved_o = r.reserved;
    assign minor_o = r.minor_o;
    assign wake_o = r.wake;
    assign interval_code_o = r.code;
    assign interval_ms_o = r.ms;
    assign bandwidth_o = r.bw;
    assign rate_mult_o = r.mult;
    assign rate_khz_o = r.khz;
    assign preamble_o = r.pre;

endmodule : bsc_rx

/* bsc_shift_map.sv */
`timescale 1ns/1ps
module bsc_shift_map
    import bsc_pkg::*;
(
    input wire logic [7:0] sig_i,
    output logic [10:0] shift_o
);
    // ----------------------------------------------------------------
    // Gray mapping of eight signaling bits
    // ----------------------------------------------------------------
    // R20: leading-bit XOR terms
    genvar i;
    generate
        for (i = `BSC_SHIFT_ONE_POS + 1; i <= 10; i++)
        begin : g_gray
            assign shift_o[i] = ^sig_i[7 -: (11 - i)];
        end
    endgenerate

    // R20: marker one, zero tail
    assign shift_o[`BSC_SHIFT_ONE_POS] = 1'b1;
    assign shift_o[`BSC_SHIFT_ONE_POS-1:0] = '0;
endmodule : bsc_shift_map

/* bsc_tx.sv */
// Behaviour
// R1: Root value 137 on every symbol
// R2: At least four symbols per bootstrap
// R3: Seed value identifies minor version
// R4: Minor version zero sends exactly four
// R5: Symbol 1 carries eight bits MSB first
// R6: Symbol 1: wake, interval code, bandwidth
// R7: Interval code 31 never transmitted
// R8: Interval code maps to milliseconds scale
// R9: Next start inside signaled interval window
// R10: Bandwidth codes 6, 7, 8, wider MHz
// R11: Wide bandwidth code never transmitted
// R12: Symbol 2 carries eight bits MSB first
// R13: Symbol 2: wake then rate multiplier
// R14: Sample rate is (N+16) times 0.384MHz
// R15: Multiplier above 80 reserved, flagged
// R16: Receiver discards bootstraps with reserved content
// R17: Symbol 3 carries eight bits MSB first
// R18: Symbol 3 preamble layout passed unchecked
// R19: Wake bits form two-bit wake field
// R20: Relative shift from Gray-mapped bits
// R21: Sync symbol shift zero, shifts accumulate
// R22: Decoder outputs fields, valid, reserved flag
`timescale 1ns/1ps
module bsc_tx
    import bsc_pkg::*;
#(
    parameter int MS_CYCLES = `BSC_MS_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [2:0] minor_i,
    input wire logic wake_first_i,
    input wire logic [4:0] interval_code_i,
    input wire logic [1:0] bandwidth_i,
    input wire logic wake_second_i,
    input wire logic [6:0] rate_mult_i,
    input wire logic [7:0] preamble_i,
    output logic ready_o,
    output logic err_o,
    output logic late_o,
    bsc_link_if.tx_mp link
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bsc_tx_state_t r;
    bsc_tx_state_t n;
    logic [7:0] sig_w;
    logic [10:0] rel_w;
    logic fields_bad;
    logic ms_tick;

    // ----------------------------------------------------------------
    // Request screening
    // ----------------------------------------------------------------
    // Reserved values are refused at the door, so nothing reserved
    // can ever reach the link.
    always_comb
    begin
        fields_bad = 1'b0;
        // R7: no interval code 31
        if (interval_code_i == `BSC_CODE_NONE)
        begin
            fields_bad = 1'b1;
        end
        // R11: no wide bandwidth code
        if (bandwidth_i == `BSC_BW_WIDE)
        begin
            fields_bad = 1'b1;
        end
        // R15: multiplier limited to 80
        if (rate_mult_i > `BSC_MULT_MAX)
        begin
            fields_bad = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Symbol payload selection
    // ----------------------------------------------------------------
    always_comb
    begin
        case (r.sym)
            2'h1: sig_w = r.b1;
            2'h2: sig_w = r.b2;
            2'h3: sig_w = r.b3;
            default: sig_w = 8'h00;
        endcase
    end

    bsc_shift_map u_map (
        .sig_i(sig_w),
        .shift_o(rel_w)
    );

    assign ms_tick = (r.div == 17'(MS_CYCLES - 1));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.err = 1'b0;
        n.lk_valid = 1'b0;

        // Millisecond divider; elapsed time saturates rather than wraps
        // so a long pause never looks like a short one.
        if (ms_tick)
        begin
            n.div = '0;
            if (r.elapsed != `BSC_T_SAT)
            begin
                n.elapsed = r.elapsed + 13'h0001;
            end
        end
        else
        begin
            n.div = r.div + 17'h0_0001;
        end

        case (r.state)
            BSC_IDLE:
            begin
                // R9: window upper bound missed
                if (r.armed && (r.elapsed >= r.hi))
                begin
                    n.late = 1'b1;
                    n.armed = 1'b0;
                end
                if (req_i && r.ready)
                begin
                    if (fields_bad)
                    begin
                        n.err = 1'b1;
                    end
                    else
                    begin
                        // R5: eight bits MSB first
                        // R6: wake, interval, bandwidth
                        // R10: bandwidth code passed as is
                        // R19: first wake bit
                        n.b1 = {wake_first_i, interval_code_i, bandwidth_i};
                        // R12: eight bits MSB first
                        // R13: wake then multiplier
                        // R14: multiplier N carried raw
                        // R19: second wake bit
                        n.b2 = {wake_second_i, rate_mult_i};
                        // R17: eight bits MSB first
                        // R18: preamble passed unchecked
                        n.b3 = preamble_i;
                        // R3: seed from minor version
                        n.seed = bsc_seed(minor_i);
                        // R8: window bounds in ms
                        // R9: bounds from this start
                        n.lo = bsc_interval_ms(interval_code_i);
                        n.hi = bsc_interval_ms(interval_code_i + 5'h01);
                        n.div = '0;
                        n.elapsed = '0;
                        n.armed = 1'b1;
                        n.late = r.armed && (r.elapsed >= r.hi);
                        n.sym = `BSC_FIRST_SYM;
                        n.state = BSC_SEND;
                    end
                end
            end
            BSC_SEND:
            begin
                n.lk_valid = 1'b1;
                n.lk_idx = r.sym;
                // R1: fixed root 137
                n.lk_root = `BSC_ROOT_V0;
                n.lk_seed = r.seed;
                if (r.sym == `BSC_FIRST_SYM)
                begin
                    // R21: sync symbol shift zero
                    n.lk_sig = 8'h00;
                    n.lk_rel = '0;
                    n.lk_abs = '0;
                end
                else
                begin
                    // R20: mapped relative shift
                    n.lk_sig = sig_w;
                    n.lk_rel = rel_w;
                    // R21: accumulate modulo 2048
                    n.lk_abs = r.lk_abs + rel_w;
                end
                // R2: four symbols sent
                // R4: exactly four for all
                if (r.sym == `BSC_LAST_SYM)
                begin
                    n.state = BSC_IDLE;
                end
                n.sym = r.sym + 2'h1;
            end
            default:
            begin
                n.state = BSC_IDLE;
            end
        endcase

        // R9: no start before lower bound
        n.ready = (n.state == BSC_IDLE) &&
                  (!n.armed || (n.elapsed >= n.lo));
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign ready_o = r.ready;
    assign err_o = r.err;
    assign late_o = r.late;
    assign link.valid = r.lk_valid;
    assign link.idx = r.lk_idx;
    assign link.root = r.lk_root;
    assign link.seed = r.lk_seed;
    assign link.sig = r.lk_sig;
    assign link.rel_shift = r.lk_rel;
    assign link.abs_shift = r.lk_abs;

endmodule : bsc_tx
